//--- verilog/lrodt_pkg.sv
// constants, register map and decode functions for the led ramp timing block
package lrodt_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int BASE_TICK_US  = 2500;
  localparam int BASE_TICK_CYC = BASE_TICK_US * 1000 / CLK_PERIOD_NS;
  localparam int QUANTUM_MS    = 250;
  localparam int QUANTUM_TICKS = QUANTUM_MS * 1000 / BASE_TICK_US;
  localparam int RAMP_STEPS    = 100;
  localparam int PWM_PERIOD_US = 500;
  localparam int PWM_SLOT_CYC  =
    PWM_PERIOD_US * 1000 / CLK_PERIOD_NS / RAMP_STEPS;

  // ----------------------------------------------------------------
  // register map (word index, byte address is four times it)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_DUTY = 8'h93;
  localparam logic [7:0] IDX_RAMP = 8'h94;
  localparam logic [7:0] IDX_HOLD = 8'h95;
  localparam logic [7:0] IDX_CTRL = 8'hC0;
  localparam logic [7:0] IDX_STAT = 8'hC1;

  localparam logic [7:0] RST_DUTY  = 8'hF0;
  localparam logic [7:0] RST_RAMP  = 8'h00;
  localparam logic [7:0] RST_HOLD  = 8'h00;
  localparam logic [7:0] RST_CTRL  = 8'h04;
  localparam logic [7:0] MASK_RAMP = 8'h3F;
  localparam logic [7:0] MASK_HOLD = 8'h7F;
  localparam logic [7:0] MASK_CTRL = 8'h07;

  localparam int RISE_LSB  = 3;
  localparam int FALL_LSB  = 0;
  localparam int GAP_LSB   = 4;
  localparam int HOLD_LSB  = 0;
  localparam int CEIL_LSB  = 4;
  localparam int FLOOR_LSB = 0;
  localparam int CTRL_ACT  = 0;
  localparam int CTRL_BRTH = 1;
  localparam int CTRL_POL  = 2;
  localparam int STAT_STATE_LSB = 8;

  // ----------------------------------------------------------------
  // decode functions
  // ----------------------------------------------------------------
  function automatic logic [6:0] ceil_pct(input logic [3:0] c);
    logic [6:0] t [16];
    t = '{7'd7, 7'd9, 7'd11, 7'd14, 7'd17, 7'd20, 7'd23, 7'd26,
          7'd30, 7'd35, 7'd40, 7'd46, 7'd53, 7'd63, 7'd77, 7'd100};
    return t[c];
  endfunction

  function automatic logic [6:0] floor_pct(input logic [3:0] c);
    return (c == 4'h0) ? 7'd0 : ceil_pct(c - 4'h1);
  endfunction

  // quarter-second quanta for rise, fall and breathe gap codes
  function automatic logic [3:0] rate_quanta(input logic [2:0] c);
    return (c == 3'h7) ? 4'h8 : {1'b0, c};
  endfunction

  function automatic logic [4:0] hold_quanta(input logic [3:0] c);
    if (c <= 4'h7) begin
      return {1'b0, c};
    end else if (c <= 4'hC) begin
      return 5'd10 + {c[2:0], 1'b0};
    end
    return 5'd20;
  endfunction

  function automatic logic [6:0] ramp_duty(input logic [6:0] lo,
                                           input logic [6:0] hi,
                                           input logic [6:0] p);
    logic [13:0] span;
    span = 14'h0;
    if (hi <= lo) begin
      return lo;
    end
    span = 14'(hi - lo) * 14'(p) / 14'(RAMP_STEPS);
    return lo + span[6:0];
  endfunction

endpackage

//--- verilog/lrodt_pwm.sv
// pwm pin driver with polarity inversion
module lrodt_pwm #(
  parameter int SLOT_CYC = lrodt_pkg::PWM_SLOT_CYC
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [6:0] duty_i,
  input  wire logic       invert_i,
  output logic            pwm_o
);

  localparam int SW = $clog2(SLOT_CYC + 1);

  logic [SW-1:0] slot_q, slot_d;
  logic [6:0]    step_q, step_d;
  logic          pwm_q,  pwm_d;

  // ----------------------------------------------------------------
  // period counter and compare
  // ----------------------------------------------------------------
  always_comb begin
    slot_d = slot_q + SW'(1);
    step_d = step_q;
    if (slot_q == SW'(SLOT_CYC - 1)) begin
      slot_d = '0;
      step_d = (step_q == 7'(lrodt_pkg::RAMP_STEPS - 1)) ? 7'd0
                                                       : step_q + 7'd1;
    end
    pwm_d = (step_q < duty_i) ^ invert_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slot_q <= '0;
      step_q <= '0;
      pwm_q  <= 1'b0;
    end else begin
      slot_q <= slot_d;
      step_q <= step_d;
      pwm_q  <= pwm_d;
    end
  end

  assign pwm_o = pwm_q;

  full_duty_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (duty_i == 7'd100) |=> (pwm_q == !$past(invert_i)))
    else $error("full duty does not hold the pin at its active level");

endmodule

//--- verilog/lrodt_top.sv
// led direct ramp, hold delay and breathe gap timing with wishbone registers
// ----------------------------------------------------------------
// How it works
// - direct mode ramps duty floor to ceiling over rise time, bits 5..3
// - direct mode ramps duty ceiling to floor over fall time, bits 2..0
// - rate code 0 is instant, 1..6 are 250 ms steps, 7 is 2 s
// - direct mode holds ceiling before ramping down; inverted polarity drives the complement of the level
// - breathe mode rests inactive for the gap in bits 6..4 per breath
// - gap code 0 is none, 1..6 are 0.25 s steps, 7 is 2 s
// - direct hold starts at deactivation, fall starts after it expires
// - one 4-bit hold field in bits 3..0 serves the single led in direct mode
// - hold 0 is zero, to 7 250 ms steps, 8..12 0.5 s steps, else 5 s
// - direct waveform combines rise, fall, limits, hold and polarity
// - direct limits apply at once; breathe picks them up on reactivation
// - ceiling is the upper nibble, floor the lower nibble of duty byte
// ----------------------------------------------------------------
module lrodt_top #(
  parameter int BASE_TICK_CYC = lrodt_pkg::BASE_TICK_CYC,
  parameter int ADR_W         = 10
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  output logic                  led_pwm_o
);

  localparam int TW = $clog2(BASE_TICK_CYC + 1);
  localparam logic [6:0] P_TOP = 7'(lrodt_pkg::RAMP_STEPS);

  typedef enum logic [2:0] {
    S_OFF, S_RISE, S_ON, S_HOLD, S_FALL, S_GAP
  } lrodt_state_t;

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  logic [7:0]  duty_reg_q, duty_reg_d;
  logic [7:0]  ramp_q,     ramp_d;
  logic [7:0]  hold_q,     hold_d;
  logic [7:0]  ctrl_q,     ctrl_d;
  logic        ack_q,      ack_d;
  logic [31:0] dat_q,      dat_d;
  logic        req;
  logic [7:0]  idx;
  lrodt_state_t state_q, state_d;
  logic [6:0]   duty_q,  duty_d;
  always_comb begin
    req        = wb_cyc_i && wb_stb_i && !ack_q;
    idx        = wb_adr_i[ADR_W-1:2];
    ack_d      = req;
    dat_d      = dat_q;
    duty_reg_d = duty_reg_q;
    ramp_d     = ramp_q;
    hold_d     = hold_q;
    ctrl_d     = ctrl_q;
    if (req && wb_we_i && wb_sel_i[0]) begin
      unique case (idx)
        lrodt_pkg::IDX_DUTY: duty_reg_d = wb_dat_i[7:0];
        lrodt_pkg::IDX_RAMP:
          ramp_d = wb_dat_i[7:0] & lrodt_pkg::MASK_RAMP;
        lrodt_pkg::IDX_HOLD:
          hold_d = wb_dat_i[7:0] & lrodt_pkg::MASK_HOLD;
        lrodt_pkg::IDX_CTRL: ctrl_d = wb_dat_i[7:0] & lrodt_pkg::MASK_CTRL;
        default: ;
      endcase
    end
    if (req) begin
      dat_d = 32'h0;
      unique case (idx)
        lrodt_pkg::IDX_DUTY: dat_d[7:0] = duty_reg_q;
        lrodt_pkg::IDX_RAMP: dat_d[7:0] = ramp_q;
        lrodt_pkg::IDX_HOLD: dat_d[7:0] = hold_q;
        lrodt_pkg::IDX_CTRL: dat_d[7:0] = ctrl_q;
        lrodt_pkg::IDX_STAT: begin
          dat_d[6:0] = duty_q;
          dat_d[lrodt_pkg::STAT_STATE_LSB +: 3] = state_q;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      duty_reg_q <= lrodt_pkg::RST_DUTY;
      ramp_q     <= lrodt_pkg::RST_RAMP;
      hold_q     <= lrodt_pkg::RST_HOLD;
      ctrl_q     <= lrodt_pkg::RST_CTRL;
      ack_q      <= 1'b0;
      dat_q      <= 32'h0;
    end else begin
      duty_reg_q <= duty_reg_d;
      ramp_q     <= ramp_d;
      hold_q     <= hold_d;
      ctrl_q     <= ctrl_d;
      ack_q      <= ack_d;
      dat_q      <= dat_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ----------------------------------------------------------------
  // time base
  // ----------------------------------------------------------------
  logic [TW-1:0] tick_cnt_q, tick_cnt_d;
  logic          tick_q,     tick_d;
  always_comb begin
    tick_d     = 1'b0;
    tick_cnt_d = tick_cnt_q + TW'(1);
    if (tick_cnt_q == TW'(BASE_TICK_CYC - 1)) begin
      tick_cnt_d = '0;
      tick_d     = 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      tick_q     <= tick_d;
    end
  end

  // ----------------------------------------------------------------
  // ramp and delay sequencer
  // ----------------------------------------------------------------
  logic [6:0]  p_q,   p_d;
  logic [3:0]  div_q, div_d;
  logic [10:0] cnt_q, cnt_d;
  logic [7:0]  lim_q, lim_d;
  logic        act, brth, pol, step;
  logic [3:0]  rise_qn, fall_qn, gap_qn, rq;
  logic [4:0]  hold_qn;
  logic [10:0] hold_ticks, gap_ticks;
  logic [7:0]  lim;
  always_comb begin
    act     = ctrl_q[lrodt_pkg::CTRL_ACT];
    brth    = ctrl_q[lrodt_pkg::CTRL_BRTH];
    pol     = ctrl_q[lrodt_pkg::CTRL_POL];
    rise_qn = lrodt_pkg::rate_quanta(
      ramp_q[lrodt_pkg::RISE_LSB +: 3]);
    fall_qn = lrodt_pkg::rate_quanta(
      ramp_q[lrodt_pkg::FALL_LSB +: 3]);
    gap_qn  = lrodt_pkg::rate_quanta(
      hold_q[lrodt_pkg::GAP_LSB +: 3]);
    hold_qn = lrodt_pkg::hold_quanta(
      hold_q[lrodt_pkg::HOLD_LSB +: 4]);
    hold_ticks = 11'(hold_qn) * 11'(lrodt_pkg::QUANTUM_TICKS);
    gap_ticks  = 11'(gap_qn) * 11'(lrodt_pkg::QUANTUM_TICKS);
    rq      = (state_q == S_RISE) ? rise_qn : fall_qn;
    step    = tick_q && (rq != 4'h0) && (div_q == rq - 4'h1);
    lim     = brth ? lim_q : duty_reg_q;
    lim_d   = (state_q == S_OFF) ? duty_reg_q : lim_q;
    state_d = state_q;
    p_d     = p_q;
    div_d   = div_q;
    cnt_d   = cnt_q;
    unique case (state_q)
      S_OFF: begin
        p_d = 7'd0;
        if (act) begin
          state_d = S_RISE;
          div_d   = 4'h0;
        end
      end
      S_RISE: begin
        if (!act && !brth) begin
          state_d = S_HOLD;
          cnt_d   = 11'd0;
        end else if (rise_qn == 4'h0 || (step && p_q == P_TOP - 7'd1)) begin
          p_d     = P_TOP;
          div_d   = 4'h0;
          state_d = brth ? S_FALL : S_ON;
        end else if (step) begin
          p_d   = p_q + 7'd1;
          div_d = 4'h0;
        end else if (tick_q) begin
          div_d = div_q + 4'h1;
        end
      end
      S_ON: begin
        if (!act || brth) begin
          cnt_d   = 11'd0;
          div_d   = 4'h0;
          state_d = (brth || hold_qn == 5'd0) ? S_FALL : S_HOLD;
        end
      end
      S_HOLD: begin
        if (act) begin
          div_d   = 4'h0;
          state_d = (p_q == P_TOP) ? S_ON : S_RISE;
        end else if (cnt_q >= hold_ticks) begin
          div_d   = 4'h0;
          state_d = S_FALL;
        end else if (tick_q) begin
          cnt_d = cnt_q + 11'd1;
        end
      end
      S_FALL: begin
        if (act && !brth) begin
          div_d   = 4'h0;
          state_d = S_RISE;
        end else if (p_q == 7'd0 || fall_qn == 4'h0 ||
                     (step && p_q == 7'd1)) begin
          p_d   = 7'd0;
          cnt_d = 11'd0;
          div_d = 4'h0;
          if (!brth) begin
            state_d = S_OFF;
          end else begin
            state_d = (gap_qn == 4'h0) ? S_RISE : S_GAP;
          end
        end else if (step) begin
          p_d   = p_q - 7'd1;
          div_d = 4'h0;
        end else if (tick_q) begin
          div_d = div_q + 4'h1;
        end
      end
      S_GAP: begin
        if (cnt_q >= gap_ticks) begin
          div_d   = 4'h0;
          state_d = S_RISE;
        end else if (tick_q) begin
          cnt_d = cnt_q + 11'd1;
        end
      end
    endcase
    if (brth && !act) begin
      state_d = S_OFF;
      p_d     = 7'd0;
    end
    duty_d = lrodt_pkg::ramp_duty(
      lrodt_pkg::floor_pct(lim[lrodt_pkg::FLOOR_LSB +: 4]),
      lrodt_pkg::ceil_pct(lim[lrodt_pkg::CEIL_LSB +: 4]), p_q);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= S_OFF;
      p_q     <= 7'd0;
      div_q   <= 4'h0;
      cnt_q   <= 11'd0;
      lim_q   <= lrodt_pkg::RST_DUTY;
      duty_q  <= 7'd0;
    end else begin
      state_q <= state_d;
      p_q     <= p_d;
      div_q   <= div_d;
      cnt_q   <= cnt_d;
      lim_q   <= lim_d;
      duty_q  <= duty_d;
    end
  end

  // ----------------------------------------------------------------
  // pin driver
  // ----------------------------------------------------------------
  lrodt_pwm #(
    .SLOT_CYC (lrodt_pkg::PWM_SLOT_CYC)
  ) u_pwm (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .duty_i   (duty_q),
    .invert_i (!pol),
    .pwm_o    (led_pwm_o)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence deact_s;
    state_q == S_ON && !act && !brth;
  endsequence
  sequence hold_run_s;
    state_q == S_HOLD && !act;
  endsequence
  ack_once_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");
  tick_range_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    tick_q |-> ##1 !tick_q ##1 (tick_cnt_q == TW'(2)))
    else $error("time base tick spacing wrong");
  rise_instant_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state_q == S_RISE && act && rise_qn == 4'h0) |=> (p_q == P_TOP))
    else $error("zero rise code did not jump to ceiling");
  rise_top_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state_q == S_RISE && act && step && p_q == P_TOP - 7'd1)
    |=> (p_q == P_TOP) ##1
        (duty_q >= lrodt_pkg::ceil_pct($past(lim[lrodt_pkg::CEIL_LSB +: 4]))))
    else $error("rise did not end at the ceiling");
  fall_step_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state_q == S_FALL && !act && !brth && step && p_q > 7'd1)
    |=> (p_q == $past(p_q) - 7'd1))
    else $error("fall step did not lower the level by one");
  hold_start_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    deact_s ##0 (hold_qn != 5'd0) |=> state_q == S_HOLD)
    else $error("deactivation did not start the hold delay");
  hold_level_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    hold_run_s ##1 hold_run_s |-> ##1 $stable(duty_q))
    else $error("level moved during hold delay");
  hold_bound_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state_q == S_HOLD) |-> (cnt_q <= hold_ticks))
    else $error("hold count passed the decoded delay");
  gap_enter_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state_q == S_FALL && brth && act && step && p_q == 7'd1 &&
     gap_qn != 4'h0)
    |=> state_q == S_GAP ##1 p_q == 7'd0)
    else $error("breath did not rest for the gap");
  reg_zero_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ramp_q[7:6] == 2'b00 && hold_q[7] == 1'b0)
    else $error("unused timing register bits are set");
  duty_live_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state_q == S_ON && !brth) ##1 (state_q == S_ON && !brth)
    |-> duty_q == lrodt_pkg::ceil_pct($past(duty_reg_q[7:4])))
    else $error("direct ceiling change not applied at once");

endmodule

//--- test/lrodt_tb_top.sv
// self-checking bench for the led ramp, hold delay and breathe gap block
module lrodt_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // clock, reset and bus signals
  // ----------------------------------------------------------------
  localparam int TICK = 5;
  localparam int QC   = 100 * TICK;
  logic        clk_i;
  logic        rst_i;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [9:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat;
  logic [31:0] dat_o;
  logic        ack;
  logic        pwm;
  logic [31:0] rdat;
  int          err_total   = 0;
  int          comparisons = 0;
  int          cyc_cnt     = 0;

  lrodt_top #(
    .BASE_TICK_CYC (TICK),
    .ADR_W         (10)
  ) i_lrodt_top (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .wb_cyc_i  (cyc),
    .wb_stb_i  (stb),
    .wb_we_i   (we),
    .wb_adr_i  (adr),
    .wb_sel_i  (sel),
    .wb_dat_i  (dat),
    .wb_dat_o  (dat_o),
    .wb_ack_o  (ack),
    .led_pwm_o (pwm)
  );

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
  end

  // ----------------------------------------------------------------
  // compare, bus and timing tasks
  // ----------------------------------------------------------------
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected value at %0t: got %h expected %h", $time, got,
               exp);
    end
  endtask

  // durations and pin counts may be off by a tick phase and a bus poll
  task automatic chk_time(input int got, input int exp);
    comparisons++;
    if (got < exp - 20 || got > exp + 40) begin
      err_total++;
      $display("unexpected count at %0t: got %h expected %h", $time, got,
               exp);
    end
  endtask

  task automatic wb_access(input logic w, input logic [7:0] idx,
                           input logic [7:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {idx, 2'b00};
    dat <= {24'h0, d};
    sel <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 100);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    chk_val(32'(n < 100), 32'h1);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    wb_access(1'b1, idx, d, 4'h1);
  endtask

  task automatic rd(input logic [7:0] idx);
    wb_access(1'b0, idx, 8'h00, 4'hF);
  endtask

  task automatic wait_state(input logic [2:0] st, input int t0,
                            output int el);
    int n;
    n = 0;
    do begin
      rd(8'hC1);
      n++;
    end while (rdat[10:8] !== st && n < 20000);
    el = cyc_cnt - t0;
    chk_val({29'h0, rdat[10:8]}, {29'h0, st});
  endtask

  function automatic int rq(input int c);
    return (c == 7) ? 8 : c;
  endfunction

  function automatic int hq(input int c);
    if (c <= 7) begin
      return c;
    end
    if (c <= 12) begin
      return 10 + 2 * (c - 8);
    end
    return 20;
  endfunction

  task automatic direct_run(input int r, input int f, input int h);
    int el;
    int t0;
    wr(8'h94, 8'(r * 8 + f));
    wr(8'h95, 8'(h));
    wr(8'hC0, 8'h05);
    t0 = cyc_cnt;
    wait_state(3'h2, t0, el);
    chk_time(el, rq(r) * QC);
    wr(8'hC0, 8'h04);
    t0 = cyc_cnt;
    if (h != 0) begin
      rd(8'hC1);
      chk_val({21'h0, rdat[10:0]}, {21'h0, 3'h3, 8'd100});
    end
    wait_state(3'h0, t0, el);
    chk_time(el, (hq(h) + rq(f)) * QC);
  endtask

  task automatic count_high(output int n);
    n = 0;
    repeat (5000) begin
      @(posedge clk_i);
      if (pwm === 1'b1) begin
        n++;
      end
    end
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    int rc [5];
    int fc [5];
    int hc [5];
    int gc [2];
    int el;
    int t0;
    int n;
    rc = '{0, 1, 7, 6, 4};
    fc = '{0, 7, 1, 2, 0};
    hc = '{0, 1, 8, 12, 13};
    gc = '{2, 7};
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = '0;
    sel = '0;
    dat = '0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h94);
    chk_val(rdat, 32'h00);
    rd(8'h95);
    chk_val(rdat, 32'h00);
    rd(8'h93);
    chk_val(rdat, 32'hF0);
    wr(8'h94, 8'hFF);
    rd(8'h94);
    chk_val(rdat, 32'h3F);
    wr(8'h95, 8'hFF);
    rd(8'h95);
    chk_val(rdat, 32'h7F);
    wb_access(1'b1, 8'h94, 8'h00, 4'h2);
    rd(8'h94);
    chk_val(rdat, 32'h3F);
    wr(8'h80, 8'h55);
    rd(8'h80);
    chk_val(rdat, 32'h00);
    for (int i = 0; i < 5; i++) begin
      direct_run(rc[i], fc[i], hc[i]);
    end
    wr(8'h94, 8'h09);
    foreach (gc[i]) begin
      wr(8'h95, 8'(gc[i] * 16));
      wr(8'hC0, 8'h07);
      wait_state(3'h5, cyc_cnt, el);
      t0 = cyc_cnt;
      wait_state(3'h1, t0, el);
      chk_time(el, rq(gc[i]) * QC);
      wr(8'hC0, 8'h04);
      wait_state(3'h0, cyc_cnt, el);
    end
    wr(8'h94, 8'h00);
    wr(8'h95, 8'h00);
    wr(8'h93, 8'h92);
    wr(8'hC0, 8'h05);
    wait_state(3'h2, cyc_cnt, el);
    // status duty trails the state by one cycle: read it again
    rd(8'hC1);
    chk_val({25'h0, rdat[6:0]}, 32'd35);
    count_high(n);
    chk_time(n, 1750);
    wr(8'hC0, 8'h01);
    count_high(n);
    chk_time(n, 3250);
    wr(8'hC0, 8'h00);
    wait_state(3'h0, cyc_cnt, el);
    rd(8'hC1);
    chk_val({25'h0, rdat[6:0]}, 32'd9);
    wr(8'hC0, 8'h05);
    wait_state(3'h2, cyc_cnt, el);
    wr(8'h93, 8'hF0);
    rd(8'hC1);
    chk_val({25'h0, rdat[6:0]}, 32'd100);
    wr(8'hC0, 8'h04);
    wait_state(3'h0, cyc_cnt, el);
    results;
  end

  initial begin
    repeat (90000) @(posedge clk_i);
    err_total++;
    results;
  end
endmodule
